// *** fsr_consts.svh ***
// constants of the flash status read port
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

`define FSR_OPC_STATUS_READ   8'hd7
`define FSR_BYTE_WIDTH        8
`define FSR_BIT_CNT_LAST      3'h7
`define FSR_BIT_CNT_RESET     3'h0

`define FSR_B1_READY_BIT      7
`define FSR_B1_COMPARE_BIT    6
`define FSR_B1_CAPACITY_HI    5
`define FSR_B1_CAPACITY_LO    2
`define FSR_B1_PROTECT_BIT    1
`define FSR_B1_PAGE_SIZE_BIT  0

`define FSR_B2_READY_BIT      7
`define FSR_B2_RSVD6_BIT      6
`define FSR_B2_FAIL_BIT       5
`define FSR_B2_RSVD4_BIT      4
`define FSR_B2_RSVD3_BIT      3
`define FSR_B2_RSVD_LOW_HI    2
`define FSR_B2_RSVD_LOW_LO    0

`define FSR_RESERVED_VALUE    1'h0
`define FSR_COMPARE_RESET     1'h0
`define FSR_FAIL_RESET        1'h0
`define FSR_BYTE_RESET        8'h00
`define FSR_CAPACITY_DEFAULT  4'h5

`endif

// *** fsr_pkg.sv ***
// types of the flash status read port
`default_nettype none

package fsr_pkg;
	typedef enum logic [1:0] {
		FSR_ST_IDLE,
		FSR_ST_OPCODE,
		FSR_ST_STATUS,
		FSR_ST_IGNORE
	} fsr_state_type;

	typedef logic [7:0] fsr_byte_type;
endpackage : fsr_pkg

`default_nettype wire

// *** fsr_status_if.sv ***
// carrier of the two live status bytes between the modules
`default_nettype none

interface fsr_status_if;
	fsr_pkg::fsr_byte_type status_low_byte;
	fsr_pkg::fsr_byte_type status_high_byte;

	modport src (output status_low_byte, output status_high_byte);
	modport snk (input status_low_byte, input status_high_byte);
endinterface : fsr_status_if

`default_nettype wire

// *** fsr_status_regs.sv ***
// status flags and assembly of the two status bytes
`include "fsr_consts.svh"
`default_nettype none

module fsr_status_regs (
	input  wire logic        clk_in,                // system clock
	input  wire logic        rst_n_in,              // synchronised reset, active low
	input  wire logic        busy_in,               // internal operation running
	input  wire logic        compare_done_in,       // compare finished, pulse
	input  wire logic        compare_mismatch_in,   // compare outcome with done
	input  wire logic        protect_sw_in,         // protection enabled by command
	input  wire logic        protect_hw_in,         // protection enabled by pin
	input  wire logic        page_binary_in,        // 1 = 512 byte page
	input  wire logic        erase_prog_done_in,    // erase/program ended, pulse
	input  wire logic        erase_prog_fail_in,    // some byte failed, with done
	input  wire logic        erase_prog_abort_in,   // operation aborted, with done
	input  wire logic [3:0]  capacity_code_in,      // fixed capacity code
	fsr_status_if.src        stat                   // live status bytes
);
	logic                  compare_q;
	logic                  compare_d;
	logic                  erase_program_fail_q;
	logic                  erase_program_fail_d;
	fsr_pkg::fsr_byte_type low_q;
	fsr_pkg::fsr_byte_type low_d;
	fsr_pkg::fsr_byte_type high_q;
	fsr_pkg::fsr_byte_type high_d;

	always_comb begin
		compare_d = compare_q;
		if (compare_done_in) begin
			compare_d = compare_mismatch_in; // R8 R16
		end
		erase_program_fail_d = erase_program_fail_q;
		// an aborted operation leaves the flag alone
		if (erase_prog_done_in && !erase_prog_abort_in) begin
			erase_program_fail_d = erase_prog_fail_in; // R12 R13 R14
		end
		low_d = `FSR_BYTE_RESET;
		low_d[`FSR_B1_READY_BIT] = !busy_in; // R6
		low_d[`FSR_B1_COMPARE_BIT] = compare_q; // R8
		low_d[`FSR_B1_CAPACITY_HI:`FSR_B1_CAPACITY_LO] = capacity_code_in; // R9
		low_d[`FSR_B1_PROTECT_BIT] = protect_sw_in | protect_hw_in; // R10
		low_d[`FSR_B1_PAGE_SIZE_BIT] = page_binary_in; // R11
		high_d = `FSR_BYTE_RESET;
		high_d[`FSR_B2_READY_BIT] = !busy_in; // R6
		high_d[`FSR_B2_RSVD6_BIT] = `FSR_RESERVED_VALUE; // R15
		high_d[`FSR_B2_FAIL_BIT] = erase_program_fail_q; // R12
		high_d[`FSR_B2_RSVD4_BIT] = `FSR_RESERVED_VALUE; // R15
		high_d[`FSR_B2_RSVD3_BIT] = `FSR_RESERVED_VALUE; // R15
		high_d[`FSR_B2_RSVD_LOW_HI:`FSR_B2_RSVD_LOW_LO] = {3{`FSR_RESERVED_VALUE}}; // R15
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			compare_q <= `FSR_COMPARE_RESET;
			erase_program_fail_q <= `FSR_FAIL_RESET;
			low_q <= `FSR_BYTE_RESET;
			high_q <= `FSR_BYTE_RESET;
		end else begin
			compare_q <= compare_d;
			erase_program_fail_q <= erase_program_fail_d;
			low_q <= low_d;
			high_q <= high_d;
		end
	end

	assign stat.status_low_byte = low_q;
	assign stat.status_high_byte = high_q;
endmodule : fsr_status_regs

`default_nettype wire

// *** fsr_status_port.sv ***
// serial status read port of the flash device
//
// Function
// (R1) status read accepted even while busy
// (R2) opcode d7h then one bit per clock
// (R3) after second byte restart with first byte
// (R4) bytes sampled live, ready bit per byte
// (R5) chip select high ends read, output floats
// (R6) ready bit 0 busy, 1 ready
// (R7) host polls until ready rises
// (R8) compare bit 1 on any mismatch
// (R9) fixed four-bit capacity code in 5:2
// (R10) protect bit set by software or pin
// (R11) page size bit 1 means 512
// (R12) fail flag reports last erase/program failure
// (R13) aborted operations never set fail flag
// (R14) fail flag refreshed after every operation; aborted ones leave it unchanged
// (R15) reserved high bits 6,4,3 read zero
// (R16) compare completion updates compare bit
// (R17) msb first, shifted on falling clock
`include "fsr_consts.svh"
`default_nettype none

module fsr_status_port #(
	parameter logic [3:0] CAPACITY_CODE = `FSR_CAPACITY_DEFAULT // arbitrary value
) (
	input  wire logic        sys_clk_in,            // system clock, 100 MHz
	input  wire logic        rst_n_in,              // async reset, active low
	input  wire logic        sck_in,                // serial clock pin
	input  wire logic        cs_n_in,               // chip select pin, active low
	input  wire logic        si_in,                 // serial data in pin
	output logic             so_out,                // serial data out pin value
	output logic             so_oe_out,             // serial data out drive enable
	input  wire logic        busy_in,               // internal operation running
	input  wire logic        compare_done_in,       // compare finished, pulse
	input  wire logic        compare_mismatch_in,   // compare outcome with done
	input  wire logic        protect_sw_in,         // protection enabled by command
	input  wire logic        protect_hw_in,         // protection enabled by pin
	input  wire logic        page_binary_in,        // 1 = 512 byte page
	input  wire logic        erase_prog_done_in,    // erase/program ended, pulse
	input  wire logic        erase_prog_fail_in,    // some byte failed, with done
	input  wire logic        erase_prog_abort_in,   // operation aborted, with done
	output logic             status_active_out      // status read in progress
);
	logic                  rst_s1_q;
	logic                  rst_s2_q;
	logic                  rst_n;

	logic                  sck_s1_q;
	logic                  sck_s2_q;
	logic                  sck_s3_q;
	logic                  cs_s1_q;
	logic                  cs_s2_q;
	logic                  si_s1_q;
	logic                  si_s2_q;
	logic                  sck_rise;
	logic                  sck_fall;
	logic                  selected;

	fsr_pkg::fsr_state_type state_q;
	fsr_pkg::fsr_state_type state_d;
	logic [2:0]            bit_cnt_q;
	logic [2:0]            bit_cnt_d;
	fsr_pkg::fsr_byte_type opcode_q;
	fsr_pkg::fsr_byte_type opcode_d;
	fsr_pkg::fsr_byte_type shift_q;
	fsr_pkg::fsr_byte_type shift_d;
	logic                  high_sel_q;
	logic                  high_sel_d;
	logic                  so_q;
	logic                  so_d;
	logic                  oe_q;
	logic                  oe_d;
	fsr_pkg::fsr_byte_type next_opcode;
	fsr_pkg::fsr_byte_type load_byte;

	fsr_status_if stat ();

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'h0;
			rst_s2_q <= 1'h0;
		end else begin
			rst_s1_q <= 1'h1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// pins cross into the system clock; second stages feed logic, sck also a third stage for edges
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sck_s1_q <= 1'h0;
			sck_s2_q <= 1'h0;
			sck_s3_q <= 1'h0;
			cs_s1_q <= 1'h1;
			cs_s2_q <= 1'h1;
			si_s1_q <= 1'h0;
			si_s2_q <= 1'h0;
		end else begin
			sck_s1_q <= sck_in;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			cs_s1_q <= cs_n_in;
			cs_s2_q <= cs_s1_q;
			si_s1_q <= si_in;
			si_s2_q <= si_s1_q;
		end
	end

	assign sck_rise = sck_s2_q & ~sck_s3_q;
	assign sck_fall = ~sck_s2_q & sck_s3_q;
	assign selected = ~cs_s2_q;

	fsr_status_regs u_regs (
		.clk_in              (sys_clk_in),
		.rst_n_in            (rst_n),
		.busy_in             (busy_in),
		.compare_done_in     (compare_done_in),
		.compare_mismatch_in (compare_mismatch_in),
		.protect_sw_in       (protect_sw_in),
		.protect_hw_in       (protect_hw_in),
		.page_binary_in      (page_binary_in),
		.erase_prog_done_in  (erase_prog_done_in),
		.erase_prog_fail_in  (erase_prog_fail_in),
		.erase_prog_abort_in (erase_prog_abort_in),
		.capacity_code_in    (CAPACITY_CODE),
		.stat                (stat.src)
	);

	assign next_opcode = {opcode_q[6:0], si_s2_q};
	// busy never blocks the read: bytes are taken fresh at each byte start
	assign load_byte = high_sel_q ? stat.status_high_byte : stat.status_low_byte; // R1 R4

	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		opcode_d = opcode_q;
		shift_d = shift_q;
		high_sel_d = high_sel_q;
		so_d = so_q;
		oe_d = oe_q;
		if (!selected) begin
			// deselect may come mid-byte; state, bit count, byte select and output enable return to rest
			state_d = fsr_pkg::FSR_ST_IDLE; // R5
			bit_cnt_d = `FSR_BIT_CNT_RESET;
			high_sel_d = 1'h0;
			oe_d = 1'h0; // R5
		end else begin
			case (state_q)
				fsr_pkg::FSR_ST_IDLE: begin
					state_d = fsr_pkg::FSR_ST_OPCODE;
					bit_cnt_d = `FSR_BIT_CNT_RESET;
					high_sel_d = 1'h0;
				end
				fsr_pkg::FSR_ST_OPCODE: begin
					// opcode bits are taken on rising clock edges only
					if (sck_rise) begin
						opcode_d = next_opcode;
						bit_cnt_d = bit_cnt_q + 3'h1;
						if (bit_cnt_q == `FSR_BIT_CNT_LAST) begin
							if (next_opcode == `FSR_OPC_STATUS_READ) begin
								state_d = fsr_pkg::FSR_ST_STATUS; // R2
							end else begin
								state_d = fsr_pkg::FSR_ST_IGNORE;
							end
						end
					end
				end
				fsr_pkg::FSR_ST_STATUS: begin
					if (sck_fall) begin
						oe_d = 1'h1; // R2
						bit_cnt_d = bit_cnt_q + 3'h1;
						if (bit_cnt_q == `FSR_BIT_CNT_RESET) begin
							so_d = load_byte[7]; // R4 R17
							shift_d = {load_byte[6:0], 1'h0};
						end else begin
							so_d = shift_q[7]; // R17
							shift_d = {shift_q[6:0], 1'h0};
						end
						if (bit_cnt_q == `FSR_BIT_CNT_LAST) begin
							high_sel_d = ~high_sel_q; // R3
						end
					end
				end
				fsr_pkg::FSR_ST_IGNORE: begin
					// other commands belong to other logic; the output stays off
					oe_d = 1'h0;
				end
				default: begin
					state_d = fsr_pkg::FSR_ST_IDLE;
					oe_d = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= fsr_pkg::FSR_ST_IDLE;
			bit_cnt_q <= `FSR_BIT_CNT_RESET;
			opcode_q <= `FSR_BYTE_RESET;
			shift_q <= `FSR_BYTE_RESET;
			high_sel_q <= 1'h0;
			so_q <= 1'h0;
			oe_q <= 1'h0;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			opcode_q <= opcode_d;
			shift_q <= shift_d;
			high_sel_q <= high_sel_d;
			so_q <= so_d;
			oe_q <= oe_d;
		end
	end

	assign so_out = so_q;
	assign so_oe_out = oe_q;
	assign status_active_out = (state_q == fsr_pkg::FSR_ST_STATUS);
endmodule : fsr_status_port

`default_nettype wire

// *** fsr_status_checker.sv ***
// assertions on the pins of the status read port
`default_nettype none
module fsr_status_checker (
	input wire logic sys_clk_in,       // system clock
	input wire logic rst_n_in,         // reset, active low
	input wire logic sck_in,           // serial clock
	input wire logic cs_n_in,          // chip select
	input wire logic so_out,           // serial data out
	input wire logic so_oe_out,        // drive enable
	input wire logic status_active_out // read in progress
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_cs_off; cs_n_in [*5] |-> !so_oe_out; endproperty
	a_cs_off: assert property (p_cs_off) else $error("so driven while deselected");
	property p_act_off; cs_n_in [*5] |-> !status_active_out; endproperty
	a_act_off: assert property (p_act_off) else $error("read active while deselected");
	property p_end_bound; $rose(cs_n_in) |-> ##[1:5] !so_oe_out; endproperty
	a_end_bound: assert property (p_end_bound) else $error("so not released");
	property p_no_early; $fell(cs_n_in) |-> !so_oe_out [*8]; endproperty
	a_no_early: assert property (p_no_early) else $error("so driven before opcode");
	property p_first; $rose(so_oe_out) |-> !sck_in && status_active_out; endproperty
	a_first: assert property (p_first) else $error("output started off edge");
	property p_shift; $changed(so_out) && so_oe_out |-> !sck_in; endproperty
	a_shift: assert property (p_shift) else $error("so moved while clock high");
	property p_oe_hold; so_oe_out && !cs_n_in |=> so_oe_out; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("output stopped while selected");
	property p_act_hold; status_active_out && !cs_n_in |=> status_active_out; endproperty
	a_act_hold: assert property (p_act_hold) else $error("read ended while selected");
	property p_oe_act; so_oe_out |-> status_active_out; endproperty
	a_oe_act: assert property (p_oe_act) else $error("so driven outside status read");
endmodule : fsr_status_checker

bind fsr_status_port fsr_status_checker u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.sck_in(sck_in), .cs_n_in(cs_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
	.status_active_out(status_active_out));
`default_nettype wire

// *** fsr_host_model.sv ***
// spi host model polling the status port
`default_nettype none
module fsr_host_model (
	output logic     sck_out,  // serial clock, mode 0 or mode 3
	output logic     cs_n_out, // chip select
	output logic     si_out,   // data to device
	input wire logic so_in,    // data from device
	input wire logic so_oe_in  // device drives so
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam realtime HALF = 62.5;
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end
	// odd offset keeps the link unrelated in phase
	task automatic sel();
		#3 cs_n_out = 1'b0;
		#HALF;
	endtask : sel
	// mode 3: clock idles high; the leading fall before the opcode is ignored
	task automatic sel3();
		sck_out = 1'b1;
		#HALF cs_n_out = 1'b0;
		#HALF sck_out = 1'b0;
	endtask : sel3
	task automatic desel3();
		#HALF sck_out = 1'b1;
		#HALF cs_n_out = 1'b1;
		#100;
	endtask : desel3
	// clock stands still outside frames; a floating so reads as z
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			si_out = tx[i];
			#HALF sck_out = 1'b1;
			rx[i] = so_oe_in ? so_in : 1'bz;
			#HALF sck_out = 1'b0;
		end
	endtask : xfer
	task automatic desel();
		cs_n_out = 1'b1;
		si_out = ~si_out;
		#100;
	endtask : desel
endmodule : fsr_host_model
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the status read port
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] CAP = 4'h6; // arbitrary value
	logic clk = 1'h0, rst_n = 1'h0, sck, cs_n, si, so, oe, act, busy = 1'h1, cdone = 1'h0, cmis = 1'h0;
	logic psw = 1'h0, phw = 1'h0, pbin = 1'h0, edone = 1'h0, efail = 1'h0, eabort = 1'h0;
	logic cmp_e = 1'h0, fail_e = 1'h0;
	logic [7:0] rx;
	int n_errors = 0, samples_checked = 0;
	always #5 clk = ~clk;
	fsr_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(oe));
	fsr_status_port #(.CAPACITY_CODE(CAP)) DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .sck_in(sck),
		.cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(oe), .busy_in(busy), .compare_done_in(cdone),
		.compare_mismatch_in(cmis), .protect_sw_in(psw), .protect_hw_in(phw), .page_binary_in(pbin),
		.erase_prog_done_in(edone), .erase_prog_fail_in(efail), .erase_prog_abort_in(eabort),
		.status_active_out(act));
	function automatic logic [7:0] lo();
		return {~busy, cmp_e, CAP, psw | phw, pbin};
	endfunction : lo
	function automatic logic [7:0] hi();
		return {~busy, 1'b0, fail_e, 5'h00};
	endfunction : hi
	task automatic summarize();
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd();
		host.sel();
		host.xfer(8'hd7, 8, rx);
		host.xfer(8'h00, 8, rx);
		chk(rx, lo());
		host.xfer(8'h00, 8, rx);
		chk(rx, hi());
		host.desel();
	endtask : rd
	task automatic t_live();
		host.sel();
		host.xfer(8'hd7, 8, rx);
		host.xfer(8'h00, 8, rx);
		chk(rx, lo());
		// busy drops once byte one is launched; byte two is loaded later and must see it
		@(negedge clk) busy = 1'h0;
		host.xfer(8'h00, 8, rx);
		chk(rx, hi());
		host.xfer(8'h00, 8, rx);
		chk(rx, lo());
		host.desel();
	endtask : t_live
	task automatic cmp(input logic m);
		@(negedge clk);
		cmis = m;
		cdone = 1'b1;
		cmp_e = m;
		@(negedge clk) cdone = 1'b0;
		rd();
	endtask : cmp
	task automatic ep(input logic f, input logic a);
		@(negedge clk);
		efail = f;
		eabort = a;
		edone = 1'b1;
		if (!a)
			fail_e = f;
		@(negedge clk) edone = 1'b0;
		rd();
	endtask : ep
	task automatic t_flags();
		cmp(1'b1);
		cmp(1'b0);
		ep(1'b1, 1'b0);
		ep(1'b0, 1'b0);
		ep(1'b1, 1'b1);
		@(negedge clk) psw = 1'b1;
		rd();
		@(negedge clk) {psw, phw, pbin} = 3'b011;
		rd();
	endtask : t_flags
	task automatic t_refuse();
		host.sel();
		host.xfer(8'h0b, 8, rx);
		host.xfer(8'h00, 8, rx);
		chk({6'h00, act, oe}, 8'h00);
		host.desel();
	endtask : t_refuse
	task automatic t_mode3();
		host.sel3();
		host.xfer(8'hd7, 8, rx);
		host.xfer(8'h00, 8, rx);
		chk(rx, lo());
		host.xfer(8'h00, 8, rx);
		chk(rx, hi());
		host.desel3();
	endtask : t_mode3
	task automatic t_abort();
		host.sel();
		host.xfer(8'hd7, 8, rx);
		host.xfer(8'h00, 3, rx);
		host.desel();
		chk({7'h00, oe}, 8'h00);
		rd();
	endtask : t_abort
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_live();
		t_flags();
		t_refuse();
		t_abort();
		t_mode3();
		summarize();
	end
	initial begin
		#200us;
		n_errors++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
